// ### tb/ppo_equip.sv
// far-side equipment model: measures output pulses, drives status pins
`timescale 1ns/100ps
`default_nettype none
module ppo_equip (
  input  wire logic   ref_clk,
  input  wire logic   pulseOut,
  input  wire logic   polHigh,
  input  wire logic   posReq,
  input  wire logic   syncReq,
  output logic        posValidPin,
  output logic        timeSyncPin,
  output logic        rose,
  output logic        fin,
  output logic [15:0] wid
);
  logic        actD = 1'b0;
  logic [15:0] run  = 16'h0000;
  wire         act  = (pulseOut === polHigh);
  // pins move off the clock edge, like an unrelated receiver
  always @(negedge ref_clk) begin
    posValidPin <= posReq;
    timeSyncPin <= syncReq;
  end
  // width in clocks of each active stretch, reported when it ends
  always @(posedge ref_clk) begin
    actD <= act;
    rose <= act & ~actD;
    fin  <= ~act & actD;
    run  <= act ? run + 16'h0001 : 16'h0000;
    if (~act & actD) begin
      wid <= run;
    end
  end
endmodule
`default_nettype wire

// ### tb/ppo_top_tb.sv
// self-checking bench for the programmable pulse output
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("mismatch %s exp %h got %h", nm, e, g); \
  end \
end
module ppo_top_tb;
  localparam int TK = 10; // short tick: one second is 1000 clocks
  localparam logic [31:0] SW [6] = '{32'h000a0001, 32'h000a0003, 32'h000a0000,
                                     32'h000a0000, 32'h00170000, 32'h00010000};
  localparam logic [31:0] TT [3] = '{32'h00001e00, 32'h00171e00, 32'h00011e00};
  logic        ref_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        wbCyc   = 1'b0;
  logic        wbStb   = 1'b0;
  logic        wbWe    = 1'b0;
  logic [7:0]  wbAdr   = 8'h00;
  logic [3:0]  wbSel   = 4'hf;
  logic [31:0] wbDat   = 32'h00000000;
  logic [31:0] datO;
  logic        ackO;
  logic        posReq  = 1'b0;
  logic        syncReq = 1'b0;
  logic        posPin;
  logic        syncPin;
  logic        pulseOut;
  logic        pol     = 1'b1;
  logic        armed   = 1'b0;
  logic        armRise = 1'b0;
  logic        rose;
  logic        fin;
  logic [15:0] wid;
  logic [15:0] eW;
  logic [31:0] eR;
  logic        p;
  logic        s;
  logic [9:0]  len;
  ppo_pkg::ppo_mode_t md;
  logic [15:0] plsQ[$];
  logic [31:0] rdQ[$];
  int          miscompares = 0;
  int          cmp_count   = 0;
  int          seed        = 32'h9b180937;

  always #4 ref_clk = ~ref_clk;

  ppo_top #(.TICK_CYCLES(TK)) ppo_top_inst (
    .ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
    .wb_dat_o(datO), .wb_ack_o(ackO), .posValidPin(posPin),
    .timeSyncPin(syncPin), .pulseOut(pulseOut));

  ppo_equip ppo_equip_inst (
    .ref_clk(ref_clk), .pulseOut(pulseOut), .polHigh(pol), .posReq(posReq),
    .syncReq(syncReq), .posValidPin(posPin), .timeSyncPin(syncPin),
    .rose(rose), .fin(fin), .wid(wid));

  // results as they appear, checked against the oldest note
  always @(posedge ref_clk) begin
    if (rose === 1'b1) begin
      armRise <= armed;
    end
    if (fin === 1'b1 && armRise) begin
      eW = plsQ.size() ? plsQ.pop_front() : 16'hffff;
      `CHK("pulse width", eW, wid)
    end
    if (ackO === 1'b1 && wbWe === 1'b0) begin
      eR = rdQ.size() ? rdQ.pop_front() : 32'hffffffff;
      `CHK("read data", eR, datO)
    end
  end

  // classic single cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= w;
    wbAdr <= a;
    wbDat <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ackO !== 1'b1);
    `CHK("ack wait", 2, n)
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    wb(1'b0, a, 32'h00000000);
  endtask

  function automatic logic [31:0] cw(input ppo_pkg::ppo_mode_t m, input logic h,
                                     input logic e);
    cw = {24'h000000, 1'b0, e, h, pol, m};
  endfunction

  task automatic waitc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic lvl(input logic act, input string nm);
    `CHK(nm, act ? pol : ~pol, pulseOut)
  endtask

  // arms a window expecting n pulses of width w; tail lets late ones end
  task automatic win(input int pre, input int span, input int n, input logic [15:0] w);
    waitc(pre);
    for (int i = 0; i < n; i++) plsQ.push_back(w);
    armed <= 1'b1;
    waitc(span);
    armed <= 1'b0;
    waitc(250);
    `CHK("pulses left", 0, plsQ.size())
    plsQ.delete();
  endtask

  task automatic final_report();
    $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog: the whole run needs about 37000 clocks
  initial begin
    waitc(60000);
    miscompares++;
    final_report();
  end

  initial begin
    waitc(20);
    resetn <= 1'b1;
    lvl(1'b0, "rest after reset");
    rd(ppo_pkg::OFS_CTRL, 32'h00000010);
    rd(8'hfc, 32'h00000000);
    wb(1'b1, ppo_pkg::OFS_LEN, 32'h00000000);
    rd(ppo_pkg::OFS_LEN, 32'h00000001);
    wb(1'b1, ppo_pkg::OFS_LEN, 32'h000007d0);
    rd(ppo_pkg::OFS_LEN, 32'h000003e8);
    for (int k = 0; k < 2; k++) begin
      pol = k[0];
      wb(1'b1, ppo_pkg::OFS_CTRL, cw(ppo_pkg::MODE_IDLE, 1'b0, 1'b1));
      waitc(5);
      lvl(1'b0, "idle");
    end
    $display("test idle done");
    pol = 1'b1;
    for (int i = 0; i < 6; i++) wb(1'b1, ppo_pkg::OFS_SW + 8'(4 * i), SW[i]);
    wb(1'b1, ppo_pkg::OFS_CTRL, cw(ppo_pkg::MODE_TIMER, 1'b0, 1'b1));
    wb(1'b1, ppo_pkg::OFS_TIME, 32'h000a0000);
    waitc(500);
    lvl(1'b0, "equal pair");
    waitc(1000);
    lvl(1'b1, "pair on");
    waitc(2000);
    lvl(1'b0, "pair off");
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, ppo_pkg::OFS_TIME, TT[k]);
      waitc(20);
      lvl(k < 2, "over midnight");
    end
    $display("test timer done");
    wb(1'b1, ppo_pkg::OFS_CTRL, cw(ppo_pkg::MODE_TIMER, 1'b0, 1'b0));
    wb(1'b1, ppo_pkg::OFS_TIME, TT[0]);
    waitc(20);
    lvl(1'b0, "before sync");
    syncReq <= 1'b1;
    waitc(20);
    lvl(1'b1, "after sync");
    syncReq <= 1'b0;
    waitc(20);
    lvl(1'b0, "sync lost");
    wb(1'b1, ppo_pkg::OFS_CTRL, cw(ppo_pkg::MODE_TIMER, 1'b1, 1'b0));
    waitc(5);
    lvl(1'b1, "holdover");
    $display("test enable done");
    for (int k = 0; k < 12; k++) begin
      md = ppo_pkg::ppo_mode_t'(4'(8 + k % 3));
      p = 1'($random(seed));
      s = 1'($random(seed));
      pol = 1'($random(seed));
      posReq <= p;
      syncReq <= s;
      wb(1'b1, ppo_pkg::OFS_CTRL, cw(md, 1'b1, 1'b1));
      waitc(12);
      lvl(md == ppo_pkg::MODE_POS ? p : md == ppo_pkg::MODE_TSYNC ? s : p & s, "status");
    end
    $display("test status done");
    for (int k = 0; k < 2; k++) begin
      len = k ? 10'h001 + 10'($random(seed) & 15) : 10'h000;
      pol = 1'($random(seed));
      wb(1'b1, ppo_pkg::OFS_LEN, {22'h000000, len});
      wb(1'b1, ppo_pkg::OFS_CTRL, cw(ppo_pkg::MODE_PPS, 1'b1, 1'b1));
      wb(1'b1, ppo_pkg::OFS_TIME, 32'h00000000);
      win(500, 2000, 2, 16'(len == 10'h000 ? 10'h001 : len) * 16'(TK));
    end
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, ppo_pkg::OFS_CTRL, cw(k ? ppo_pkg::MODE_PPH : ppo_pkg::MODE_PPM, 1'b1, 1'b1));
      wb(1'b1, ppo_pkg::OFS_TIME, k ? 32'h00003b3a : 32'h0000003a);
      win(500, 2000, 1, 16'(len) * 16'(TK));
    end
    $display("test per second done");
    pol = 1'b1;
    wb(1'b1, ppo_pkg::OFS_TIMEOUT, 32'h00000000);
    wb(1'b1, ppo_pkg::OFS_CTRL, cw(ppo_pkg::MODE_MARKS, 1'b1, 1'b1));
    wb(1'b1, ppo_pkg::OFS_TIME, 32'h0000003a);
    win(500, 2000, 1, 16'(ppo_pkg::MARK_ZERO) * 16'(TK));
    syncReq <= 1'b1;
    waitc(20);
    syncReq <= 1'b0;
    wb(1'b1, ppo_pkg::OFS_TIMEOUT, 32'h00000001);
    wb(1'b1, ppo_pkg::OFS_TIME, 32'h0000003a);
    win(500, 2000, 0, 16'(ppo_pkg::MARK_ZERO) * 16'(TK));
    $display("test marks done");
    wb(1'b1, ppo_pkg::OFS_LEN, 32'h00000003);
    wb(1'b1, ppo_pkg::OFS_SHOT, 32'h00000002);
    wb(1'b1, ppo_pkg::OFS_CTRL, cw(ppo_pkg::MODE_SINGLE, 1'b1, 1'b1));
    wb(1'b1, ppo_pkg::OFS_TIME, 32'h00000000);
    win(500, 3000, 1, 16'(3 * TK));
    $display("test single shot done");
    wb(1'b1, ppo_pkg::OFS_CYCLE, 32'h00000007);
    wb(1'b1, ppo_pkg::OFS_CTRL, cw(ppo_pkg::MODE_CYCLIC, 1'b1, 1'b1));
    wb(1'b1, ppo_pkg::OFS_TIME, 32'h00173b37);
    win(500, 4000, 0, 16'(3 * TK));
    win(0, 750, 1, 16'(3 * TK));
    win(0, 5750, 0, 16'(3 * TK));
    win(0, 750, 1, 16'(3 * TK));
    $display("test cyclic done");
    final_report();
  end
endmodule
`default_nettype wire

// ### verilog/ppo_marks.sv
// long-wave second-mark telegram encoder, local time
`timescale 1ns/100ps
`default_nettype none
module ppo_marks (
  input  wire ppo_pkg::ppo_tod_t tod,
  input  wire logic              summer,
  output logic                   bitOne,
  output logic                   noMark
);

  logic [5:0] nm;
  logic [4:0] nh;
  logic [7:0] mb;
  logic [7:0] hb;
  logic [59:0] frame;

  function automatic logic [7:0] bcd(input logic [5:0] v);
    bcd = {4'(v / 6'h0a), 4'(v % 6'h0a)};
  endfunction

  // the telegram announces the minute that starts at the next mark 0
  always_comb begin
    nm = (tod.minute == ppo_pkg::MIN_LAST) ? 6'h00 : 6'(tod.minute + 6'h01);
    nh = tod.hour;
    if (tod.minute == ppo_pkg::MIN_LAST) begin
      nh = (tod.hour == ppo_pkg::HOUR_LAST) ? 5'h00 : 5'(tod.hour + 5'h01);
    end
    mb = bcd(nm);
    hb = bcd({1'b0, nh});
    frame = '0;
    frame[17] = summer;
    frame[18] = ~summer;
    frame[20] = 1'b1;
    frame[27:21] = mb[6:0];
    frame[28] = ^mb[6:0];
    frame[34:29] = hb[5:0];
    frame[35] = ^hb[5:0];
    // date field unknown here; zeros keep its parity even
    bitOne = frame[tod.second];
    noMark = (tod.second == ppo_pkg::SEC_LAST);
  end

endmodule
`default_nettype wire

// ### verilog/ppo_pkg.sv
// constants, types and helpers for the programmable pulse outputs
package ppo_pkg;

  // tick timing
  localparam int TICK_NS     = 10000000;
  localparam int CLK_NS      = 8;
  localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;

  // time-of-day limits
  localparam logic [6:0] CS_LAST   = 7'h63;
  localparam logic [5:0] SEC_LAST  = 6'h3b;
  localparam logic [5:0] MIN_LAST  = 6'h3b;
  localparam logic [4:0] HOUR_LAST = 5'h17;

  // pulse length in 10 ms ticks
  localparam logic [9:0] LEN_MIN = 10'h001;
  localparam logic [9:0] LEN_MAX = 10'h3e8;
  localparam logic [9:0] LEN_RST = 10'h00a;

  // long-wave second marks in ticks: 100 ms zero, 200 ms one
  localparam logic [4:0] MARK_ZERO = 5'h0a;
  localparam logic [4:0] MARK_ONE  = 5'h14;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_TIME    = 8'h08;
  localparam logic [7:0] OFS_SW      = 8'h0c;
  localparam logic [7:0] OFS_CYCLE   = 8'h24;
  localparam logic [7:0] OFS_SHOT    = 8'h28;
  localparam logic [7:0] OFS_LEN     = 8'h2c;
  localparam logic [7:0] OFS_TIMEOUT = 8'h30;
  localparam int         SW_WORDS    = 6;

  // time word layout: hours [20:16], minutes [13:8], seconds [5:0]
  localparam logic [31:0] TIME_MASK = 32'h001f3f3f;

  typedef enum logic [3:0] {
    MODE_IDLE, MODE_TIMER, MODE_CYCLIC, MODE_MARKS, MODE_SINGLE,
    MODE_PPS, MODE_PPM, MODE_PPH, MODE_POS, MODE_TSYNC, MODE_ALLSYNC
  } ppo_mode_t;

  typedef struct packed {
    ppo_mode_t mode;
    logic      summer;
    logic      enAlways;
    logic      holdover;
    logic      polHigh;
  } ppo_ctrl_t;

  localparam ppo_ctrl_t CTRL_RST = '{mode: MODE_IDLE, summer: 1'b0, enAlways: 1'b0,
                                     holdover: 1'b0, polHigh: 1'b1};

  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } ppo_tod_t;

  typedef struct packed {
    ppo_ctrl_t               ctrl;
    logic [SW_WORDS-1:0][31:0] sw;
    logic [31:0]             cycle;
    logic [31:0]             shot;
    logic [9:0]              len;
    logic [15:0]             timeout;
    logic [20:0]             tickCnt;
    logic [6:0]              cs;
    ppo_tod_t                tod;
    logic [16:0]             cycSec;
    logic [9:0]              plsCnt;
    logic [4:0]              markCnt;
    logic [15:0]             frMin;
    logic                    everSync;
    logic                    outActive;
    logic                    pulseOut;
    logic                    ack;
    logic [31:0]             rdat;
  } ppo_state_t;

  localparam ppo_state_t ST_RST = '{ctrl: CTRL_RST, len: LEN_RST, default: '0};

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic val;
  } ppo_sync_t;

  // time word to time of day
  function automatic ppo_tod_t todOf(input logic [31:0] w);
    todOf = '{hour: w[20:16], minute: w[13:8], second: w[5:0]};
  endfunction

  // time of day to time word
  function automatic logic [31:0] wordOf(input ppo_tod_t t);
    wordOf = {11'h000, t.hour, 2'h0, t.minute, 2'h0, t.second};
  endfunction

  // time of day to seconds
  function automatic logic [16:0] secsOf(input ppo_tod_t t);
    secsOf = 17'(17'(t.hour) * 17'h00e10) + 17'(17'(t.minute) * 17'h0003c)
             + 17'(t.second);
  endfunction

endpackage

// ### verilog/ppo_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module ppo_sync (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic din,
  output logic      dout
);

  ppo_pkg::ppo_sync_t st;
  ppo_pkg::ppo_sync_t next_st;

  // s1 feeds only s2; the value moves once s2 and s3 agree
  always_comb begin
    next_st     = st;
    next_st.s1  = din;
    next_st.s2  = st.s1;
    next_st.s3  = st.s2;
    if (st.s2 == st.s3) begin
      next_st.val = st.s3;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.val;

  a_sync_agree: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st.s2 == st.s3) |=> (st.val == $past(st.s3)))
    else $error("synchroniser did not follow agreed level");

endmodule
`default_nettype wire

// ### verilog/ppo_top.sv
// programmable pulse output with wishbone register slave
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [R1] timer: three on/off pairs, any covering
// [R2] on later than off spans midnight
// [R3] equal on and off means pair unused
// [R4] polarity sets active level, opposite rests
// [R5] cyclic pulses, train realigned at midnight
// [R6] cyclic period zero to 24 hours
// [R7] uneven period: last interval shorter
// [R8] long-wave telegram coded in local time
// [R9] telegram stops after free-run timeout minutes
// [R10] single shot: one pulse per day
// [R11] length 10 ms to 10 s, 10 ms steps
// [R12] pulse per second, minute or hour
// [R13] position-valid mode follows position status
// [R14] timebase-locked mode follows sync status
// [R15] full-lock mode is AND of both
// [R16] idle mode holds output inactive
// [R17] holdover off: output off on sync loss
// [R18] enable always or after sync, default sync
// [R19] tick counter drives time and lengths
module ppo_top #(
  parameter int TICK_CYCLES = ppo_pkg::TICK_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        posValidPin,
  input  wire logic        timeSyncPin,
  output logic             pulseOut
);

  ppo_pkg::ppo_state_t st;
  ppo_pkg::ppo_state_t next_st;

  logic             posValid;
  logic             timeSync;
  logic             markOne;
  logic             markNone;
  logic             tick;
  logic             newSec;
  logic             midnight;
  logic             startPulse;
  logic             timerAct;
  logic             anyUsed;
  logic             marksStop;
  logic             selAct;
  logic             enableOk;
  logic             holdOk;
  logic             req;
  logic [16:0]      period;
  ppo_pkg::ppo_tod_t nTod;
  ppo_pkg::ppo_tod_t onT;
  ppo_pkg::ppo_tod_t offT;
  logic [31:0]      status;

  // status pins come from outside the clock domain
  ppo_sync u_pos_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .din     (posValidPin),
    .dout    (posValid)
  );

  ppo_sync u_tsync_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .din     (timeSyncPin),
    .dout    (timeSync)
  );

  // encoder looks at the second about to begin
  ppo_marks u_marks (
    .tod    (nTod),
    .summer (st.ctrl.summer),
    .bitOne (markOne),
    .noMark (markNone)
  );

  // byte-lane merge of a bus write, limited to the implemented bits
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel, input logic [31:0] mask);
    logic [31:0] be;
    be = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    merge = ((old & ~be) | (dat & be)) & mask;
  endfunction

  // time of day one second later
  function automatic ppo_pkg::ppo_tod_t incTod(input ppo_pkg::ppo_tod_t t);
    incTod = t;
    if (t.second != ppo_pkg::SEC_LAST) begin
      incTod.second = 6'(t.second + 6'h01);
    end else begin
      incTod.second = 6'h00;
      if (t.minute != ppo_pkg::MIN_LAST) begin
        incTod.minute = 6'(t.minute + 6'h01);
      end else begin
        incTod.minute = 6'h00;
        incTod.hour = (t.hour == ppo_pkg::HOUR_LAST) ? 5'h00 : 5'(t.hour + 5'h01);
      end
    end
  endfunction

  // time base: 10 ms tick, centiseconds, time of day
  always_comb begin
    tick     = (st.tickCnt == 21'(TICK_CYCLES - 1)); // R19
    newSec   = tick && (st.cs == ppo_pkg::CS_LAST);
    nTod     = incTod(st.tod);
    midnight = (nTod == '0);
    period   = ppo_pkg::secsOf(ppo_pkg::todOf(st.cycle));
  end

  // timer mode: any used pair covering the present time
  always_comb begin
    timerAct = 1'b0;
    anyUsed  = 1'b0;
    onT      = '0;
    offT     = '0;
    for (int i = 0; i < ppo_pkg::SW_WORDS / 2; i++) begin
      onT  = ppo_pkg::todOf(st.sw[2*i]);
      offT = ppo_pkg::todOf(st.sw[2*i+1]);
      if (onT < offT) begin
        anyUsed = 1'b1;
        if (st.tod >= onT && st.tod < offT) begin // R1
          timerAct = 1'b1;
        end
      end else if (onT > offT) begin
        anyUsed = 1'b1;
        if (st.tod >= onT || st.tod < offT) begin // R2
          timerAct = 1'b1;
        end
      end
      // equal times leave the pair out entirely R3
    end
  end

  // start of a length-timed pulse, decided at the second boundary
  always_comb begin
    startPulse = 1'b0;
    if (newSec) begin
      case (st.ctrl.mode)
        ppo_pkg::MODE_CYCLIC: begin
          // midnight restarts the train even if the period does not fit R7
          startPulse = midnight || (period != 17'h00000 &&
                       17'(st.cycSec + 17'h00001) >= period); // R5
        end
        ppo_pkg::MODE_SINGLE: begin
          startPulse = (nTod == ppo_pkg::todOf(st.shot)); // R10
        end
        ppo_pkg::MODE_PPS: begin
          startPulse = 1'b1; // R12
        end
        ppo_pkg::MODE_PPM: begin
          startPulse = (nTod.second == 6'h00); // R12
        end
        ppo_pkg::MODE_PPH: begin
          startPulse = (nTod.second == 6'h00) && (nTod.minute == 6'h00); // R12
        end
        default: begin
          startPulse = 1'b0;
        end
      endcase
    end
  end

  // level chosen by the mode, then gated by enable and holdover
  always_comb begin
    marksStop = !timeSync && (st.timeout != 16'h0000) && (st.frMin >= st.timeout); // R9
    case (st.ctrl.mode)
      ppo_pkg::MODE_IDLE:    selAct = 1'b0; // R16
      ppo_pkg::MODE_TIMER:   selAct = timerAct;
      ppo_pkg::MODE_CYCLIC:  selAct = (st.plsCnt != 10'h000);
      ppo_pkg::MODE_MARKS:   selAct = (st.markCnt != 5'h00) && !marksStop; // R8
      ppo_pkg::MODE_SINGLE:  selAct = (st.plsCnt != 10'h000);
      ppo_pkg::MODE_PPS:     selAct = (st.plsCnt != 10'h000);
      ppo_pkg::MODE_PPM:     selAct = (st.plsCnt != 10'h000);
      ppo_pkg::MODE_PPH:     selAct = (st.plsCnt != 10'h000);
      ppo_pkg::MODE_POS:     selAct = posValid; // R13
      ppo_pkg::MODE_TSYNC:   selAct = timeSync; // R14
      ppo_pkg::MODE_ALLSYNC: selAct = posValid && timeSync; // R15
      default:               selAct = 1'b0;
    endcase
    enableOk = st.ctrl.enAlways || st.everSync; // R18
    // loss means it was locked once; before that only the enable applies
    holdOk   = st.ctrl.holdover || timeSync || !st.everSync; // R17
  end

  // readable status word
  always_comb begin
    status = {27'h0000000, marksStop, enableOk, timeSync, posValid, st.outActive};
  end

  assign req = wb_cyc_i && wb_stb_i && !st.ack;

  // next state: bus access, time base, pulse counters, output
  always_comb begin
    next_st = st;
    next_st.ack = req;
    // time base advance R19
    next_st.tickCnt = tick ? 21'h000000 : 21'(st.tickCnt + 21'h000001);
    if (tick) begin
      next_st.cs = (st.cs == ppo_pkg::CS_LAST) ? 7'h00 : 7'(st.cs + 7'h01);
    end
    if (newSec) begin
      next_st.tod = nTod;
    end
    // seconds since the last cyclic pulse, cleared at midnight R6
    if (newSec) begin
      next_st.cycSec = (startPulse || midnight) ? 17'h00000 : 17'(st.cycSec + 17'h00001);
    end
    // pulse length in 10 ms ticks R11
    if (startPulse) begin
      next_st.plsCnt = st.len;
    end else if (tick && st.plsCnt != 10'h000) begin
      next_st.plsCnt = 10'(st.plsCnt - 10'h001);
    end
    // second marks, none on the last second of the minute R8
    if (newSec && st.ctrl.mode == ppo_pkg::MODE_MARKS && !markNone) begin
      next_st.markCnt = markOne ? ppo_pkg::MARK_ONE : ppo_pkg::MARK_ZERO;
    end else if (tick && st.markCnt != 5'h00) begin
      next_st.markCnt = 5'(st.markCnt - 5'h01);
    end
    // free-running minutes, saturating R9
    if (timeSync) begin
      next_st.frMin = 16'h0000;
    end else if (newSec && nTod.second == 6'h00 && st.frMin != 16'hffff) begin
      next_st.frMin = 16'(st.frMin + 16'h0001);
    end
    if (timeSync) begin
      next_st.everSync = 1'b1;
    end
    // writes land at the edge where the master sees ack, ahead of the time base
    if (wb_cyc_i && wb_stb_i && wb_we_i && st.ack) begin
      if (wb_adr_i == ppo_pkg::OFS_CTRL && wb_sel_i[0]) begin
        next_st.ctrl.mode     = ppo_pkg::ppo_mode_t'(wb_dat_i[3:0]);
        next_st.ctrl.polHigh  = wb_dat_i[4];
        next_st.ctrl.holdover = wb_dat_i[5];
        next_st.ctrl.enAlways = wb_dat_i[6];
        next_st.ctrl.summer   = wb_dat_i[7];
      end
      if (wb_adr_i == ppo_pkg::OFS_TIME) begin
        next_st.tod = ppo_pkg::todOf(merge(ppo_pkg::wordOf(st.tod), wb_dat_i, wb_sel_i,
                                           ppo_pkg::TIME_MASK));
        next_st.cs      = 7'h00;
        next_st.tickCnt = 21'h000000;
      end
      for (int i = 0; i < ppo_pkg::SW_WORDS; i++) begin
        if (wb_adr_i == 8'(ppo_pkg::OFS_SW + 8'(4 * i))) begin
          next_st.sw[i] = merge(st.sw[i], wb_dat_i, wb_sel_i, ppo_pkg::TIME_MASK);
        end
      end
      if (wb_adr_i == ppo_pkg::OFS_CYCLE) begin
        next_st.cycle = merge(st.cycle, wb_dat_i, wb_sel_i, ppo_pkg::TIME_MASK);
      end
      if (wb_adr_i == ppo_pkg::OFS_SHOT) begin
        next_st.shot = merge(st.shot, wb_dat_i, wb_sel_i, ppo_pkg::TIME_MASK);
      end
      if (wb_adr_i == ppo_pkg::OFS_LEN && wb_sel_i[1:0] == 2'h3) begin
        // out-of-range lengths are clamped, not refused R11
        if (wb_dat_i[15:0] < 16'(ppo_pkg::LEN_MIN)) begin
          next_st.len = ppo_pkg::LEN_MIN;
        end else if (wb_dat_i[15:0] > 16'(ppo_pkg::LEN_MAX)) begin
          next_st.len = ppo_pkg::LEN_MAX;
        end else begin
          next_st.len = wb_dat_i[9:0];
        end
      end
      if (wb_adr_i == ppo_pkg::OFS_TIMEOUT) begin
        next_st.timeout = 16'(merge({16'h0000, st.timeout}, wb_dat_i, wb_sel_i,
                                    32'h0000ffff));
      end
    end
    // read data, unmapped reads as zero
    next_st.rdat = 32'h00000000;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        ppo_pkg::OFS_CTRL:    next_st.rdat = {24'h000000, st.ctrl.summer, st.ctrl.enAlways,
                                              st.ctrl.holdover, st.ctrl.polHigh,
                                              st.ctrl.mode};
        ppo_pkg::OFS_STATUS:  next_st.rdat = status;
        ppo_pkg::OFS_TIME:    next_st.rdat = ppo_pkg::wordOf(st.tod);
        ppo_pkg::OFS_CYCLE:   next_st.rdat = st.cycle;
        ppo_pkg::OFS_SHOT:    next_st.rdat = st.shot;
        ppo_pkg::OFS_LEN:     next_st.rdat = {22'h000000, st.len};
        ppo_pkg::OFS_TIMEOUT: next_st.rdat = {16'h0000, st.timeout};
        default: begin
          for (int i = 0; i < ppo_pkg::SW_WORDS; i++) begin
            if (wb_adr_i == 8'(ppo_pkg::OFS_SW + 8'(4 * i))) begin
              next_st.rdat = st.sw[i];
            end
          end
        end
      endcase
    end
    // output level and polarity R4
    next_st.outActive = selAct && enableOk && holdOk;
    next_st.pulseOut  = next_st.outActive ? next_st.ctrl.polHigh : ~next_st.ctrl.polHigh;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st <= ppo_pkg::ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdat;
  assign pulseOut = st.pulseOut;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_ack_answer: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged next cycle");

  a_out_polarity: assert property (pulseOut == (st.outActive ~^ st.ctrl.polHigh)) // R4
    else $error("output level disagrees with polarity");

  a_idle_quiet: assert property ((st.ctrl.mode == ppo_pkg::MODE_IDLE) |=> !st.outActive) // R16
    else $error("idle output went active");

  a_timer_unused: assert property ( // R3
    (st.ctrl.mode == ppo_pkg::MODE_TIMER && !anyUsed) |=> !st.outActive)
    else $error("unused switch pairs drove the output");

  a_holdover_off: assert property ( // R17
    (!st.ctrl.holdover && st.everSync && !timeSync) |=> !st.outActive)
    else $error("output stayed on after sync loss");

  a_enable_gate: assert property ((!st.ctrl.enAlways && !st.everSync) |=> !st.outActive) // R18
    else $error("output active before first sync");

  a_full_lock: assert property ((st.ctrl.mode == ppo_pkg::MODE_ALLSYNC) |=> // R15
    (st.outActive == $past(posValid && timeSync && enableOk)))
    else $error("full-lock output is not the AND");

  a_cycle_midnight: assert property ( // R5
    (st.ctrl.mode == ppo_pkg::MODE_CYCLIC && newSec && midnight) |=>
    (st.plsCnt == $past(st.len) && st.cycSec == 17'h00000))
    else $error("cyclic train not realigned at midnight");

  a_pps_start: assert property ((st.ctrl.mode == ppo_pkg::MODE_PPS && newSec) |=> // R12
    (st.plsCnt == $past(st.len)) ##1 (st.plsCnt != 10'h000))
    else $error("second pulse not started with programmed length");

  a_len_range: assert property ((st.len >= ppo_pkg::LEN_MIN) && // R11
    (st.len <= ppo_pkg::LEN_MAX))
    else $error("pulse length out of range");

  a_tick_wrap: assert property (newSec |=> (st.cs == 7'h00) && (st.tickCnt == 21'h000000)) // R19
    else $error("second boundary did not clear sub-second count");

endmodule
`default_nettype wire
